// File: hdl/dcad_defs.svh
// Purpose: Constants for the command/address decode block
// Assumes: Single 10 MHz clock, synchronous reset
// Notes:   Field positions and counts named here, used by top, model and bench
`ifndef DCAD_DEFS_SVH
`define DCAD_DEFS_SVH
`define DCAD_ROW_W        16
`define DCAD_COL_W        10
`define DCAD_ADDR_W       18
`define DCAD_BANKS        8
`define DCAD_BA_W         2
`define DCAD_AP_BIT       10
`define DCAD_BC_BIT       12
`define DCAD_A14_BIT      14
`define DCAD_A15_BIT      15
`define DCAD_A16_BIT      16
`define DCAD_BL8          4'h8
`define DCAD_BC4          4'h4
`define DCAD_CL_FAST      5'h16
`define DCAD_CORE_CLKS    3'h4
`endif

// File: hdl/dcad_pkg.sv
// Purpose: Types for the command/address decode block
// Assumes: Widths written here directly; defs header not included
// Notes:   Command codes are plain enumerations, not the RAS/CAS/WE pin pattern
package dcad_pkg;
  typedef enum logic [3:0] {
    DCAD_CMD_NONE = 4'h0,
    DCAD_CMD_ACT  = 4'h1,
    DCAD_CMD_RD   = 4'h2,
    DCAD_CMD_WR   = 4'h3,
    DCAD_CMD_PRE  = 4'h4,
    DCAD_CMD_REF  = 4'h5,
    DCAD_CMD_MRS  = 4'h6,
    DCAD_CMD_ZQ   = 4'h7,
    DCAD_CMD_NOP  = 4'h8
  } dcad_cmd_type;
  typedef enum logic [2:0] {
    DCAD_B_IDLE  = 3'h1,
    DCAD_B_BURST = 3'h2,
    DCAD_B_DONE  = 3'h4
  } dcad_burst_type;
endpackage : dcad_pkg

// File: hdl/dcad_sync.sv
// Purpose: Two-stage synchroniser for the pin inputs
// Assumes: Pins asynchronous to sys_clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module dcad_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;
  always_comb
  begin
    meta_d = din;
    sync_d = meta_q;
  end
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      meta_q <= '1;
      sync_q <= '1;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign dout = sync_q;
endmodule : dcad_sync

// File: hdl/dcad_top.sv
// Purpose: Command/address decode front end of a DDR4 module
// Assumes: Pins sampled at sys_clk rising edge after two-flop sync
// Notes:   Data path, termination, parity and power-down left out
`timescale 1ns/1ps
`include "dcad_defs.svh"
// Behaviour
// - Sample command and address only on the rising clock edge.
// - Activate when activate strobe and chip select low; A16..A14 row bits (row output keeps A15..A0 only).
// - Activate high, select low: A16..A14 act as RAS, CAS, WE.
// - Read/write samples A10: high gives auto precharge.
// - Precharge: A10 low closes one bank, high closes all banks.
// - Read/write with on-the-fly enabled: A12 low chops burst.
// - Row from address on activate, column on read or write.
// - Mode register set: address is op-code, group/bank pick register.
// - Bank bits pick bank; group bit used also for refresh.
// - Eight banks kept separately, two groups of four.
// - One access moves an 8n word over four core clocks; a read/write decoded while the burst state is not idle starts no transfer.
// - Fastest grade uses read latency of 22 clocks.
// - Commands ignored while chip select sampled high.
// - Bursts run eight beats, or four when chopped.
module dcad_top (
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     cs_n,
  input  wire logic                     act_n,
  input  wire logic [`DCAD_ADDR_W-1:0]  addr,
  input  wire logic                     bg,
  input  wire logic [`DCAD_BA_W-1:0]    ba,
  input  wire logic                     otf_en,
  output logic [3:0]                    cmd,
  output logic                          cmd_valid,
  output logic [`DCAD_ROW_W-1:0]        row,
  output logic [`DCAD_COL_W-1:0]        col,
  output logic [2:0]                    bank,
  output logic                          auto_pre,
  output logic                          pre_all,
  output logic [3:0]                    burst_len,
  output logic [2:0]                    mr_sel,
  output logic [`DCAD_ADDR_W-1:0]       mr_opcode,
  output logic [`DCAD_BANKS-1:0]        bank_open,
  output logic                          bad_access,
  output logic                          burst_busy,
  output logic [4:0]                    read_lat
);
  localparam int PW = `DCAD_ADDR_W + 6;
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] pin_s;
  logic          s_cs_n;
  logic          s_act_n;
  logic          s_bg;
  logic          s_otf;
  logic [1:0]    s_ba;
  logic [`DCAD_ADDR_W-1:0] s_a;
  assign pin_raw = {cs_n, act_n, bg, otf_en, ba, addr};
  // Captured at the rising edge only, via two flops
  dcad_sync #(.W(PW)) u_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .din     (pin_raw),
    .dout    (pin_s)
  );
  assign s_a     = pin_s[`DCAD_ADDR_W-1:0];
  assign s_ba    = pin_s[`DCAD_ADDR_W+1:`DCAD_ADDR_W];
  assign s_otf   = pin_s[`DCAD_ADDR_W+2];
  assign s_bg    = pin_s[`DCAD_ADDR_W+3];
  assign s_act_n = pin_s[`DCAD_ADDR_W+4];
  assign s_cs_n  = pin_s[`DCAD_ADDR_W+5];

  function automatic dcad_pkg::dcad_cmd_type decode(
    input logic c, input logic a, input logic r, input logic k,
    input logic w);
    dcad_pkg::dcad_cmd_type res;
    res = dcad_pkg::DCAD_CMD_NONE;
    if (c)
      res = dcad_pkg::DCAD_CMD_NONE;
    else if (!a)
      res = dcad_pkg::DCAD_CMD_ACT;
    else
      case ({r, k, w})
        3'h0: res = dcad_pkg::DCAD_CMD_MRS;
        3'h1: res = dcad_pkg::DCAD_CMD_REF;
        3'h2: res = dcad_pkg::DCAD_CMD_PRE;
        3'h4: res = dcad_pkg::DCAD_CMD_WR;
        3'h5: res = dcad_pkg::DCAD_CMD_RD;
        3'h6: res = dcad_pkg::DCAD_CMD_ZQ;
        3'h7: res = dcad_pkg::DCAD_CMD_NOP;
        default: res = dcad_pkg::DCAD_CMD_NONE;
      endcase
    return res;
  endfunction : decode

  dcad_pkg::dcad_cmd_type cur;
  logic [2:0] sel_bank;
  logic       is_rw;
  assign cur = decode(s_cs_n, s_act_n, s_a[`DCAD_A16_BIT],
                      s_a[`DCAD_A15_BIT], s_a[`DCAD_A14_BIT]);
  assign sel_bank = {s_bg, s_ba};
  assign is_rw = (cur == dcad_pkg::DCAD_CMD_RD) ||
                 (cur == dcad_pkg::DCAD_CMD_WR);

  logic [3:0]  cmd_q, cmd_d;
  logic        vld_q, vld_d;
  logic [`DCAD_ROW_W-1:0] row_q, row_d;
  logic [`DCAD_COL_W-1:0] col_q, col_d;
  logic [2:0]  bank_q, bank_d;
  logic        ap_q, ap_d;
  logic        pa_q, pa_d;
  logic [3:0]  bl_q, bl_d;
  logic [2:0]  mrs_q, mrs_d;
  logic [`DCAD_ADDR_W-1:0] op_q, op_d;
  logic [`DCAD_BANKS-1:0]  open_q, open_d;
  logic        bad_q, bad_d;
  logic [4:0]  lat_q;
  dcad_pkg::dcad_burst_type bst_q, bst_d;
  logic [2:0]  core_q, core_d;
  logic        busy_q, busy_d;

  // Per-bank open flags; eight banks as two groups of four
  always_comb
  begin
    open_d = open_q;
    bad_d  = 1'b0;
    case (cur)
      dcad_pkg::DCAD_CMD_ACT: open_d[sel_bank] = 1'b1;
      dcad_pkg::DCAD_CMD_PRE:
        if (s_a[`DCAD_AP_BIT])
          open_d = '0;
        else
          open_d[sel_bank] = 1'b0;
      dcad_pkg::DCAD_CMD_RD, dcad_pkg::DCAD_CMD_WR:
      begin
        bad_d = !open_q[sel_bank];
        if (s_a[`DCAD_AP_BIT])
          open_d[sel_bank] = 1'b0;
      end
      default: open_d = open_q;
    endcase
  end

  always_comb
  begin
    cmd_d = cur;
    vld_d = (cur != dcad_pkg::DCAD_CMD_NONE);
    row_d = row_q;
    col_d = col_q;
    bank_d = bank_q;
    ap_d  = ap_q;
    pa_d  = 1'b0;
    bl_d  = bl_q;
    mrs_d = mrs_q;
    op_d  = op_q;
    if (cur == dcad_pkg::DCAD_CMD_ACT)
    begin
      row_d  = s_a[`DCAD_ROW_W-1:0];
      bank_d = sel_bank;
    end
    if (is_rw)
    begin
      col_d  = s_a[`DCAD_COL_W-1:0];
      bank_d = sel_bank;
      ap_d   = s_a[`DCAD_AP_BIT];
      bl_d   = (s_otf && !s_a[`DCAD_BC_BIT]) ? `DCAD_BC4 : `DCAD_BL8;
    end
    if (cur == dcad_pkg::DCAD_CMD_PRE)
    begin
      pa_d   = s_a[`DCAD_AP_BIT];
      bank_d = sel_bank;
    end
    if (cur == dcad_pkg::DCAD_CMD_REF)
      bank_d = sel_bank;
    if (cur == dcad_pkg::DCAD_CMD_MRS)
    begin
      op_d  = s_a;
      mrs_d = sel_bank;
    end
  end

  // Core transfer: one 8n word spans four core clocks
  always_comb
  begin
    bst_d  = bst_q;
    core_d = core_q;
    case (bst_q)
      dcad_pkg::DCAD_B_IDLE:
        if (is_rw)
        begin
          bst_d  = dcad_pkg::DCAD_B_BURST;
          core_d = `DCAD_CORE_CLKS - 3'h1;
        end
      dcad_pkg::DCAD_B_BURST:
        if (core_q == 3'h0)
          bst_d = dcad_pkg::DCAD_B_DONE;
        else
          core_d = core_q - 3'h1;
      dcad_pkg::DCAD_B_DONE: bst_d = dcad_pkg::DCAD_B_IDLE;
      default: bst_d = dcad_pkg::DCAD_B_IDLE;
    endcase
    busy_d = (bst_d == dcad_pkg::DCAD_B_BURST);
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cmd_q  <= 4'h0;
      vld_q  <= 1'b0;
      row_q  <= '0;
      col_q  <= '0;
      bank_q <= 3'h0;
      ap_q   <= 1'b0;
      pa_q   <= 1'b0;
      bl_q   <= `DCAD_BL8;
      mrs_q  <= 3'h0;
      op_q   <= '0;
      open_q <= '0;
      bad_q  <= 1'b0;
      lat_q  <= `DCAD_CL_FAST;
      bst_q  <= dcad_pkg::DCAD_B_IDLE;
      core_q <= 3'h0;
      busy_q <= 1'b0;
    end
    else
    begin
      cmd_q  <= cmd_d;
      vld_q  <= vld_d;
      row_q  <= row_d;
      col_q  <= col_d;
      bank_q <= bank_d;
      ap_q   <= ap_d;
      pa_q   <= pa_d;
      bl_q   <= bl_d;
      mrs_q  <= mrs_d;
      op_q   <= op_d;
      open_q <= open_d;
      bad_q  <= bad_d;
      lat_q  <= `DCAD_CL_FAST;
      bst_q  <= bst_d;
      core_q <= core_d;
      busy_q <= busy_d;
    end
  end

  assign cmd        = cmd_q;
  assign cmd_valid  = vld_q;
  assign row        = row_q;
  assign col        = col_q;
  assign bank       = bank_q;
  assign auto_pre   = ap_q;
  assign pre_all    = pa_q;
  assign burst_len  = bl_q;
  assign mr_sel     = mrs_q;
  assign mr_opcode  = op_q;
  assign bank_open  = open_q;
  assign bad_access = bad_q;
  assign burst_busy = busy_q;
  assign read_lat   = lat_q;

  AST_CS_MASK: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_cs_n |=> !vld_q) else $error("command taken with select high");
  AST_ACT_OPEN: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cur == dcad_pkg::DCAD_CMD_ACT) |=> open_q[$past(sel_bank)])
    else $error("activate did not open bank");
  AST_PREA: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cur == dcad_pkg::DCAD_CMD_PRE && s_a[`DCAD_AP_BIT]) |=> open_q == '0)
    else $error("precharge all left bank open");
  AST_BC4: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (is_rw && s_otf && !s_a[`DCAD_BC_BIT]) |=> bl_q == `DCAD_BC4)
    else $error("chop not applied");
  AST_BL8: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (is_rw && !(s_otf && !s_a[`DCAD_BC_BIT])) |=> bl_q == `DCAD_BL8)
    else $error("full burst not applied");
  AST_BAD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (is_rw && !open_q[sel_bank]) |=> bad_q)
    else $error("closed bank access not flagged");
  AST_CORE4: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (bst_q == dcad_pkg::DCAD_B_IDLE && is_rw) |=> burst_busy [*4] ##1
    !burst_busy) else $error("core transfer not four clocks");
  AST_AP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    is_rw |=> ap_q == $past(s_a[`DCAD_AP_BIT]))
    else $error("auto precharge flag wrong");
  AST_CL: assert property (@(posedge sys_clk) disable iff (sys_rst)
    read_lat == `DCAD_CL_FAST) else $error("latency not 22");
  AST_MRS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cur == dcad_pkg::DCAD_CMD_MRS) |=> mr_sel == $past(sel_bank))
    else $error("mode register select wrong");
  CV_ACT: cover property (@(posedge sys_clk) vld_q &&
    cmd_q == dcad_pkg::DCAD_CMD_ACT);
  CV_RD: cover property (@(posedge sys_clk) vld_q &&
    cmd_q == dcad_pkg::DCAD_CMD_RD && !bad_q);
  CV_PREA: cover property (@(posedge sys_clk) pa_q);
endmodule : dcad_top

// File: sim/dcad_ctrl_model.sv
// Purpose: Controller model driving the command/address pins
// Assumes: Bench hands at most one request per cycle on go
// Notes:   Idle slots are deselects with scrambled lines, never NOP
`timescale 1ns/1ps
`include "dcad_defs.svh"
module dcad_ctrl_model (
  input  wire logic                    sys_clk,
  input  wire logic                    go,
  input  wire logic [3:0]              op,
  input  wire logic [`DCAD_ADDR_W-1:0] a,
  input  wire logic                    g,
  input  wire logic [1:0]              b,
  input  wire logic                    otf,
  output logic                         cs_n,
  output logic                         act_n,
  output logic [`DCAD_ADDR_W-1:0]      addr,
  output logic                         bg,
  output logic [1:0]                   ba,
  output logic                         otf_en
);
  logic [2:0] pins;
  initial
  begin
    cs_n = 1'b1;
    act_n = 1'b1;
    addr = '0;
    bg = 1'b0;
    ba = 2'h0;
    otf_en = 1'b0;
  end
  always_comb
  begin
    case (op)
      4'h2: pins = 3'h5;
      4'h3: pins = 3'h4;
      4'h4: pins = 3'h2;
      4'h5: pins = 3'h1;
      4'h6: pins = 3'h0;
      4'h7: pins = 3'h6;
      default: pins = 3'h7;
    endcase
  end
  // Deselect holds chip select high, and lines are inverted, not held
  always @(posedge sys_clk)
  begin
    otf_en <= otf;
    if (go)
    begin
      cs_n <= 1'b0;
      act_n <= (op != 4'h1);
      addr <= (op == 4'h1) ? a : {a[17], pins, a[13:0]};
      bg <= g;
      ba <= b;
    end
    else
    begin
      cs_n <= 1'b1;
      act_n <= ~act_n;
      addr <= ~addr;
      bg <= ~bg;
      ba <= ~ba;
    end
  end
endmodule : dcad_ctrl_model

// File: sim/ddr4_cmd_addr_decode_tb.sv
// Purpose: Self-checking bench for the command/address decode block
// Assumes: Decoded outputs appear a few cycles after the pins
// Notes:   Results matched in order against a queue of expectations
`timescale 1ns/1ps
`include "dcad_defs.svh"
module ddr4_cmd_addr_decode_tb;
  typedef struct {
    logic [3:0]  cmd;
    logic [17:0] a;
    logic [2:0]  bk;
    logic        bad;
    logic [3:0]  bl;
    logic [7:0]  opn;
  } dcad_exp_type;
  localparam logic [3:0] C_ACT = dcad_pkg::DCAD_CMD_ACT;
  localparam logic [3:0] C_RD  = dcad_pkg::DCAD_CMD_RD;
  localparam logic [3:0] C_WR  = dcad_pkg::DCAD_CMD_WR;
  localparam logic [3:0] C_PRE = dcad_pkg::DCAD_CMD_PRE;
  logic        sys_clk, sys_rst, go, g, otf;
  logic        cs_n, act_n, bg, otf_en, cmd_valid, auto_pre, pre_all;
  logic        bad_access, burst_busy;
  logic [1:0]  b, ba;
  logic [2:0]  bank, mr_sel;
  logic [3:0]  op, cmd, burst_len;
  logic [4:0]  read_lat;
  logic [7:0]  bank_open, opn;
  logic [9:0]  col;
  logic [15:0] row;
  logic [17:0] ad, addr, mr_opcode;
  int          errors, samples_checked, busy_n, i;
  dcad_exp_type exq[$];
  dcad_exp_type e;
  dcad_ctrl_model u_ctrl (.sys_clk(sys_clk), .go(go), .op(op), .a(ad),
    .g(g), .b(b), .otf(otf), .cs_n(cs_n), .act_n(act_n), .addr(addr),
    .bg(bg), .ba(ba), .otf_en(otf_en));
  dcad_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cs_n(cs_n),
    .act_n(act_n), .addr(addr), .bg(bg), .ba(ba), .otf_en(otf_en),
    .cmd(cmd), .cmd_valid(cmd_valid), .row(row), .col(col), .bank(bank),
    .auto_pre(auto_pre), .pre_all(pre_all), .burst_len(burst_len),
    .mr_sel(mr_sel), .mr_opcode(mr_opcode), .bank_open(bank_open),
    .bad_access(bad_access), .burst_busy(burst_busy),
    .read_lat(read_lat));
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic tally_and_finish();
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic ok);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("wrong value at %0t ns: output mismatch", $time);
    end
  endtask : chk
  // Bank state is tracked here so a closed-bank access is predicted
  task automatic issue(input logic [3:0] c, input logic [17:0] a,
                       input logic [2:0] k);
    dcad_exp_type x;
    x.cmd = c;
    x.a = a;
    x.bk = k;
    x.bad = 1'b0;
    x.bl = (otf && !a[12]) ? 4'h4 : 4'h8;
    if (c == C_ACT)
      opn[k] = 1'b1;
    if (c == C_RD || c == C_WR)
    begin
      x.bad = !opn[k];
      if (a[10])
        opn[k] = 1'b0;
    end
    if (c == C_PRE)
      opn = a[10] ? 8'h00 : (opn & ~(8'h01 << k));
    x.opn = opn;
    exq.push_back(x);
    @(posedge sys_clk);
    go <= 1'b1;
    op <= c;
    ad <= a;
    g <= k[2];
    b <= k[1:0];
  endtask : issue
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk) go <= 1'b0;
  endtask : idle
  always @(negedge sys_clk)
  begin
    if (burst_busy === 1'b1)
      busy_n++;
    if (cmd_valid === 1'b1)
    begin
      if (exq.size() == 0)
        chk(1'b0);
      else
      begin
        e = exq.pop_front();
        chk(cmd === e.cmd);
        chk(bank_open === e.opn);
        if (e.cmd == C_ACT)
        begin
          chk(row === e.a[15:0]);
          chk(bank === e.bk);
        end
        if (e.cmd == C_RD || e.cmd == C_WR)
        begin
          chk(col === e.a[9:0]);
          chk(bank === e.bk);
          chk(auto_pre === e.a[10]);
          chk(burst_len === e.bl);
          chk(bad_access === e.bad);
        end
        if (e.cmd == C_PRE)
          chk(pre_all === e.a[10]);
        if (e.cmd == C_PRE || e.cmd == dcad_pkg::DCAD_CMD_REF)
          chk(bank === e.bk);
        // A16..A14 carry the command pattern, all low for mode set
        if (e.cmd == dcad_pkg::DCAD_CMD_MRS)
          chk({mr_sel, mr_opcode} === {e.bk, e.a[17], 3'h0, e.a[13:0]});
      end
    end
  end
  initial
  begin
    #100000;
    errors++;
    tally_and_finish();
  end
  initial
  begin
    sys_rst = 1'b1;
    {go, g, otf, b, op, ad} = '0;
    opn = 8'h00;
    void'($urandom(32'h9ba8));
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    chk(read_lat === 5'h16);
    chk(bank_open === 8'h00);
    for (i = 0; i < 8; i++)
      issue(C_ACT, 18'($urandom), 3'(i));
    for (i = 0; i < 32; i++)
    begin
      if (i == 16)
      begin
        idle(1);
        otf <= 1'b1;
        idle(4);
      end
      issue(i[0] ? C_RD : C_WR, 18'($urandom), 3'(i));
    end
    for (i = 0; i < 8; i++)
      issue(C_ACT, 18'($urandom), 3'(i));
    issue(C_PRE, 18'h00000, 3'h3);
    issue(C_PRE, 18'h00400, 3'h0);
    for (i = 0; i < 8; i++)
      issue(dcad_pkg::DCAD_CMD_MRS, 18'($urandom), 3'(i));
    issue(dcad_pkg::DCAD_CMD_REF, 18'($urandom), 3'h4);
    issue(dcad_pkg::DCAD_CMD_ZQ, 18'($urandom), 3'h2);
    issue(C_ACT, 18'($urandom), 3'h5);
    idle(10);
    busy_n = 0;
    issue(C_RD, 18'h00000, 3'h5);
    idle(10);
    chk(busy_n == 4);
    chk(exq.size() == 0);
    tally_and_finish();
  end
endmodule : ddr4_cmd_addr_decode_tb
